// ==== bench/cascaded_interrupt_routing_tb.sv ====
// Purpose: Self-checking bench for the cascaded interrupt routing
// Assumes: Inputs change at the falling edge; outputs settle in 3 edges
// Notes: Open-drain wires are resolved here from every party's enable
`timescale 1ns/1ps
module cascaded_interrupt_routing_tb;
    import cascade_pkg::*;
    logic clk, rst_n, int_n_out, int_n_oe_n, intack_n, eoi_master, eoi_slave;
    logic [7:0] ext_vi_n, vi_n_in, vi_n_out, vi_n_oe_n, vector_out, vec_seen;
    logic cpu_type_select, end_polarity_select, vector_valid, mem_disable;
    logic [31:0] bus_line_routing_header;
    logic [7:0] slave_input_routing_header;
    logic phantom_disable_option, phantom_enable_option, ext_phantom_n;
    logic phantom_n_in, phantom_n_out, phantom_n_oe_n;
    logic [2:0] timer_out_in, timer_gate_in, timer_gate_driven;
    logic [2:0] timer_gate, timer_out;
    logic math_service_request, math_end, math_error;
    logic serial_tx_ready, serial_rx_ready;
    logic go, slow, done, timed_out, ph_seen, mem_seen;
    int mismatches, comparisons;
    int slave_code[8] = '{0, 3, 4, 5, 6, 7, 2, 1};

    assign vi_n_in = ext_vi_n & (vi_n_oe_n | vi_n_out);
    assign phantom_n_in = ext_phantom_n & (phantom_n_oe_n | phantom_n_out);

    cascaded_interrupt_routing cascaded_interrupt_routing_inst (
        .clk(clk), .rst_n(rst_n), .vi_n_in(vi_n_in), .vi_n_out(vi_n_out),
        .vi_n_oe_n(vi_n_oe_n), .int_n_out(int_n_out),
        .int_n_oe_n(int_n_oe_n), .intack_n(intack_n),
        .eoi_master(eoi_master), .eoi_slave(eoi_slave),
        .cpu_type_select(cpu_type_select),
        .end_polarity_select(end_polarity_select),
        .bus_line_routing_header(bus_line_routing_header),
        .slave_input_routing_header(slave_input_routing_header),
        .phantom_disable_option(phantom_disable_option),
        .phantom_enable_option(phantom_enable_option),
        .phantom_n_in(phantom_n_in), .phantom_n_out(phantom_n_out),
        .phantom_n_oe_n(phantom_n_oe_n), .mem_disable(mem_disable),
        .vector_out(vector_out), .vector_valid(vector_valid),
        .timer_out_in(timer_out_in),
        .math_service_request(math_service_request),
        .math_end(math_end), .math_error(math_error),
        .serial_tx_ready(serial_tx_ready),
        .serial_rx_ready(serial_rx_ready),
        .timer_gate_in(timer_gate_in),
        .timer_gate_driven(timer_gate_driven),
        .timer_gate(timer_gate), .timer_out(timer_out)
    );

    cpu_ack_model cpu_ack_model_inst (
        .clk(clk), .rst_n(rst_n), .go(go),
        .two_pulse(cpu_type_select == CPU_TWO_PULSE), .slow(slow),
        .vector_out(vector_out), .vector_valid(vector_valid),
        .phantom_n_oe_n(phantom_n_oe_n), .mem_disable(mem_disable),
        .intack_n(intack_n), .done(done), .timed_out(timed_out),
        .vec_seen(vec_seen), .ph_seen(ph_seen), .mem_seen(mem_seen)
    );

    initial
    begin
        clk = 1'b0;
        forever
            #50 clk = ~clk;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic settle();
        repeat (5) @(negedge clk);
    endtask : settle

    task automatic eoi(input logic m, input logic s);
        eoi_master = m;
        eoi_slave = s;
        @(negedge clk);
        eoi_master = 1'b0;
        eoi_slave = 1'b0;
    endtask : eoi

    // Runs one acknowledge cycle through the processor model
    task automatic ack(input logic s);
        int n;
        n = 0;
        slow = s;
        go = 1'b1;
        while (done !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 200 || timed_out !== 1'b0)
        begin
            mismatches++;
            close_out();
        end
        else
        begin
            go = 1'b0;
            repeat (8) @(negedge clk);
            check("phantom released", phantom_n_oe_n, 1'b1);
        end
    endtask : ack

    // Codes 1..8 as used by the bus line selector
    task automatic set_src(input int c, input logic v);
        case (c)
            1: serial_rx_ready = v;
            2: serial_tx_ready = v;
            3, 4, 5: timer_out_in[c-3] = v;
            6: math_service_request = v;
            7: math_end = v;
            default: math_error = v;
        endcase
    endtask : set_src

    task automatic set_slave(input int j, input logic v);
        if (j == 0)
            ext_vi_n[7] = ~v;
        else
            set_src(slave_code[j], v);
    endtask : set_slave

    initial
    begin
        repeat (30000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial
    begin
        {rst_n, eoi_master, eoi_slave, go, slow} = '0;
        {mismatches, comparisons} = '0;
        ext_vi_n = 8'hff;
        ext_phantom_n = 1'b1;
        cpu_type_select = CPU_ONE_PULSE;
        end_polarity_select = END_POL_TRUE;
        bus_line_routing_header = 32'h00000000;
        slave_input_routing_header = 8'hff;
        {phantom_disable_option, phantom_enable_option} = 2'b00;
        {timer_out_in, timer_gate_in, timer_gate_driven} = '0;
        {math_service_request, math_end, math_error} = 3'b000;
        {serial_tx_ready, serial_rx_ready} = 2'b00;
        repeat (10) @(negedge clk);
        check("reset vi oe", vi_n_oe_n, OE_N_RESET);
        check("reset int oe", int_n_oe_n, 1'b1);
        check("reset vector", vector_out, VEC_RESET);
        check("reset valid", vector_valid, 1'b0);
        check("reset gate", timer_gate, 3'h7);
        check("reset mem", mem_disable, 1'b0);
        check("reset phantom", phantom_n_oe_n, 1'b1);
        check("reset timer out", timer_out, 3'h0);
        rst_n = 1'b1;
        settle();
        math_error = 1'b1;
        settle();
        check("error to slave", int_n_oe_n, 1'b1);
        check("error to bus", vi_n_oe_n, 8'hff);
        math_error = 1'b0;
        timer_gate_driven = 3'h7;
        timer_gate_in = 3'h2;
        timer_out_in = 3'h5;
        settle();
        check("driven gate", timer_gate, 3'h2);
        check("timer out", timer_out, 3'h5);
        timer_gate_driven = 3'h0;
        timer_out_in = 3'h0;
        settle();
        check("open gate", timer_gate, 3'h7);
        phantom_enable_option = 1'b1;
        ext_phantom_n = 1'b0;
        settle();
        check("mem with phantom", mem_disable, 1'b0);
        ext_phantom_n = 1'b1;
        settle();
        check("mem no phantom", mem_disable, 1'b1);
        {phantom_disable_option, phantom_enable_option} = 2'b10;
        settle();
        check("mem disable idle", mem_disable, 1'b0);
        ext_phantom_n = 1'b0;
        settle();
        check("mem disabled", mem_disable, 1'b1);
        {phantom_disable_option, phantom_enable_option} = 2'b00;
        ext_phantom_n = 1'b1;
        settle();
        check("mem options off", mem_disable, 1'b0);
        for (int i = 0; i < 7; i++)
        begin
            ext_vi_n[i] = 1'b0;
            settle();
            check("bus int", int_n_oe_n, 1'b0);
            ack(1'b0);
            check("master vec", vec_seen, MASTER_VEC_BASE + i);
            check("phantom in ack", ph_seen, 1'b0);
            check("mem in ack", mem_seen, 1'b1);
            ext_vi_n = 8'hff;
            eoi(1'b1, 1'b0);
            settle();
            check("int idle", int_n_oe_n, 1'b1);
        end
        cpu_type_select = CPU_TWO_PULSE;
        for (int j = 0; j < 8; j++)
        begin
            set_slave(j, 1'b1);
            settle();
            ack(1'b1);
            check("slave vec", vec_seen, SLAVE_VEC_BASE + j);
            check("mem two pulse", mem_seen, 1'b1);
            set_slave(j, 1'b0);
            eoi(1'b1, 1'b1);
            settle();
        end
        slave_input_routing_header = 8'hfd;
        set_slave(1, 1'b1);
        settle();
        check("slave masked", int_n_oe_n, 1'b1);
        slave_input_routing_header = 8'hff;
        cpu_type_select = CPU_ONE_PULSE;
        ext_vi_n[3] = 1'b0;
        settle();
        ack(1'b0);
        check("master first", vec_seen, MASTER_VEC_BASE + 3);
        ext_vi_n[3] = 1'b1;
        eoi(1'b1, 1'b0);
        settle();
        ack(1'b0);
        check("slave next", vec_seen, SLAVE_VEC_BASE + 1);
        set_slave(1, 1'b0);
        eoi(1'b1, 1'b1);
        bus_line_routing_header = 32'h87654321;
        for (int c = 1; c <= 8; c++)
        begin
            set_src(c, 1'b1);
            settle();
            check("routed line", vi_n_oe_n,
                  8'(~(8'h01 << (c - 1))));
            set_src(c, 1'b0);
            settle();
        end
        end_polarity_select = END_POL_INVERT;
        settle();
        check("end inverted", vi_n_oe_n[6], 1'b0);
        math_end = 1'b1;
        settle();
        check("end inverted off", vi_n_oe_n[6], 1'b1);
        close_out();
    end
endmodule : cascaded_interrupt_routing_tb

// ==== bench/cpu_ack_model.sv ====
// Purpose: Bus processor board that runs interrupt acknowledge cycles
// Assumes: Strobe changes only at the falling edge of clk
// Notes: Prompt or slow timing, one or two acknowledge pulses
`timescale 1ns/1ps
module cpu_ack_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic two_pulse,
    input wire logic slow,
    input wire logic [7:0] vector_out,
    input wire logic vector_valid,
    input wire logic phantom_n_oe_n,
    input wire logic mem_disable,
    output logic intack_n,
    output logic done,
    output logic timed_out,
    output logic [7:0] vec_seen,
    output logic ph_seen,
    output logic mem_seen
);
    int n;
    initial
    begin
        intack_n = 1'b1;
        done = 1'b0;
        timed_out = 1'b0;
        vec_seen = 8'h00;
        ph_seen = 1'b1;
        mem_seen = 1'b0;
        forever
        begin
            @(negedge clk);
            if (go === 1'b1 && rst_n === 1'b1)
            begin
                // First pulse of a two-pulse cycle, released before the next
                if (two_pulse)
                begin
                    intack_n = 1'b0;
                    repeat (slow ? 6 : 3) @(negedge clk);
                    intack_n = 1'b1;
                    repeat (slow ? 6 : 3) @(negedge clk);
                end
                intack_n = 1'b0;
                n = 0;
                while (vector_valid !== 1'b1 && n < 40)
                begin
                    @(negedge clk);
                    n++;
                end
                timed_out = (n >= 40);
                vec_seen = vector_out;
                ph_seen = phantom_n_oe_n;
                mem_seen = mem_disable;
                repeat (slow ? 5 : 1) @(negedge clk);
                intack_n = 1'b1;
                done = 1'b1;
                while (go === 1'b1)
                    @(negedge clk);
                done = 1'b0;
            end
        end
    end
endmodule : cpu_ack_model

// ==== hw/cascade_pkg.sv ====
// Purpose: Shared constants and types for the cascaded interrupt routing
// Assumes: One 10 MHz clock, asynchronous active-low reset
// Notes: Source codes index the on-board source vector plus one
package cascade_pkg;
    localparam int NUM_LINES = 8;
    localparam int NUM_SRC = 8;
    localparam int NUM_TIMERS = 3;
    localparam int SEL_W = 4;
    // On-board source vector positions
    localparam int SRC_RX = 0;
    localparam int SRC_TX = 1;
    localparam int SRC_T0 = 2;
    localparam int SRC_MATH_SERVICE_REQUEST = 5;
    localparam int SRC_END = 6;
    localparam int SRC_ERR = 7;
    // Bus line select codes: 0 leaves the line alone, n picks source n-1
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_MAX = 4'h8;
    localparam logic [2:0] CASCADE_INPUT = 3'h7;
    localparam logic [7:0] MASTER_VEC_BASE = 8'h40;
    localparam logic [7:0] SLAVE_VEC_BASE = 8'h48;
    localparam logic CPU_TWO_PULSE = 1'b0;
    localparam logic CPU_ONE_PULSE = 1'b1;
    localparam logic END_POL_TRUE = 1'b0;
    localparam logic END_POL_INVERT = 1'b1;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] OE_N_RESET = 8'hff;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FIRST = 4'h2,
        ST_GAP = 4'h4,
        ST_SECOND = 4'h8
    } ack_state_e;
endpackage : cascade_pkg

// ==== hw/cascaded_interrupt_routing.sv ====
// Purpose: Master and slave interrupt controllers with routing and
//          acknowledge glue for a bus slave board
// Assumes: Bus pins and on-board sources are asynchronous to clk
// Notes: Open-drain outputs drive low while their enable_n is low
`timescale 1ns/1ps
// Summary of operation
// - While an acknowledge sequence runs the phantom line is driven.
// - On-board memory is disabled during acknowledge whatever the options.
// - The cpu type input picks a one-pulse or two-pulse acknowledge.
// - Master and slave controllers watch 8 bus lines and 7 board sources.
// - Master inputs win over anything arriving through the slave.
// - Bus lines 0 to 6 feed master inputs 0 to 6, the slave feeds input 7.
// - Slave inputs take line 7, timers 0 to 2, service, end, tx, rx.
// - Any local source can be routed onto any bus vectored line.
// - The math end signal passes a polarity selector before routing.
// - The math error output reaches only the bus lines, never the slave.
// - Three timer sections have their gates and outputs brought out.
// - A timer gate left undriven reads as enabled.
module cascaded_interrupt_routing
    import cascade_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] vi_n_in,
    output logic [7:0] vi_n_out,
    output logic [7:0] vi_n_oe_n,
    output logic int_n_out,
    output logic int_n_oe_n,
    input wire logic intack_n,
    input wire logic eoi_master,
    input wire logic eoi_slave,
    input wire logic cpu_type_select,
    input wire logic end_polarity_select,
    input wire logic [31:0] bus_line_routing_header,
    input wire logic [7:0] slave_input_routing_header,
    input wire logic phantom_disable_option,
    input wire logic phantom_enable_option,
    input wire logic phantom_n_in,
    output logic phantom_n_out,
    output logic phantom_n_oe_n,
    output logic mem_disable,
    output logic [7:0] vector_out,
    output logic vector_valid,
    input wire logic [2:0] timer_out_in,
    input wire logic math_service_request,
    input wire logic math_end,
    input wire logic math_error,
    input wire logic serial_tx_ready,
    input wire logic serial_rx_ready,
    input wire logic [2:0] timer_gate_in,
    input wire logic [2:0] timer_gate_driven,
    output logic [2:0] timer_gate,
    output logic [2:0] timer_out
);
    typedef struct packed {
        logic [7:0] src_s1;
        logic [7:0] src_s2;
        logic [7:0] vi_s1;
        logic [7:0] vi_s2;
        logic [5:0] gate_s1;
        logic [5:0] gate_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_d;
        logic phan_s1;
        logic phan_s2;
        ack_state_e state;
        logic [7:0] vi_oe_n;
        logic int_oe_n;
        logic phantom_oe_n;
        logic mem_dis;
        logic [7:0] vector;
        logic vec_valid;
        logic [2:0] tgate;
        logic [2:0] tout;
    } top_s;

    top_s cur_ff;
    top_s nxt_cur;
    logic [7:0] srcv;
    logic [7:0] m_req;
    logic [7:0] s_req;
    logic m_int;
    logic s_int;
    logic [2:0] m_best;
    logic [2:0] s_best;
    logic ack_now;
    logic ack_rise;
    logic take;

    assign ack_now = ~cur_ff.ack_s2;
    assign ack_rise = ack_now & ~cur_ff.ack_d;
    assign take = ack_rise && (cur_ff.state == ST_IDLE);

    always_comb
    begin
        srcv = cur_ff.src_s2;
        srcv[SRC_END] = cur_ff.src_s2[SRC_END] ^
                        end_polarity_select;
        m_req = {s_int, ~cur_ff.vi_s2[6:0]};
        s_req = {srcv[SRC_RX], srcv[SRC_TX], srcv[SRC_END], srcv[SRC_MATH_SERVICE_REQUEST],
                 srcv[SRC_T0 + 2], srcv[SRC_T0 + 1], srcv[SRC_T0],
                 ~cur_ff.vi_s2[7]} & slave_input_routing_header;
    end

    irq_core u_master
    (
        .clk(clk),
        .rst_n(rst_n),
        .req(m_req),
        .take(take),
        .eoi(eoi_master),
        .int_req(m_int),
        .best(m_best)
    );

    irq_core u_slave
    (
        .clk(clk),
        .rst_n(rst_n),
        .req(s_req),
        .take(take && m_int && (m_best == CASCADE_INPUT)),
        .eoi(eoi_slave),
        .int_req(s_int),
        .best(s_best)
    );

    always_comb
    begin
        logic [3:0] sel;
        logic drive;
        logic ack_busy;
        sel = SEL_NONE;
        drive = 1'b0;
        ack_busy = 1'b0;
        nxt_cur = cur_ff;
        nxt_cur.src_s1 = {math_error, math_end, math_service_request,
                          timer_out_in, serial_tx_ready, serial_rx_ready};
        nxt_cur.src_s2 = cur_ff.src_s1;
        nxt_cur.vi_s1 = vi_n_in;
        nxt_cur.vi_s2 = cur_ff.vi_s1;
        nxt_cur.gate_s1 = {timer_gate_driven, timer_gate_in};
        nxt_cur.gate_s2 = cur_ff.gate_s1;
        nxt_cur.ack_s1 = intack_n;
        nxt_cur.ack_s2 = cur_ff.ack_s1;
        nxt_cur.ack_d = ack_now;
        nxt_cur.phan_s1 = phantom_n_in;
        nxt_cur.phan_s2 = cur_ff.phan_s1;
        for (int l = 0; l < NUM_LINES; l++)
        begin
            sel = bus_line_routing_header[l * SEL_W +: SEL_W];
            drive = 1'b0;
            if (sel != SEL_NONE && sel <= SEL_MAX)
            begin
                drive = srcv[3'(sel - 4'h1)];
            end
            nxt_cur.vi_oe_n[l] = ~drive;
        end
        for (int t = 0; t < NUM_TIMERS; t++)
        begin
            nxt_cur.tgate[t] = cur_ff.gate_s2[3 + t] ?
                               cur_ff.gate_s2[t] : 1'b1;
        end
        nxt_cur.tout = cur_ff.src_s2[SRC_T0 +: 3];
        nxt_cur.int_oe_n = ~m_int;
        case (cur_ff.state)
            ST_IDLE:
            begin
                nxt_cur.vec_valid = 1'b0;
                if (ack_rise)
                begin
                    nxt_cur.state = ST_FIRST;
                    if (m_int && m_best == CASCADE_INPUT)
                    begin
                        nxt_cur.vector = SLAVE_VEC_BASE +
                                         {5'h00, s_best};
                    end
                    else
                    begin
                        nxt_cur.vector = MASTER_VEC_BASE +
                                         {5'h00, m_best};
                    end
                    nxt_cur.vec_valid = (cpu_type_select == CPU_ONE_PULSE);
                end
            end
            ST_FIRST:
            begin
                if (!ack_now)
                begin
                    nxt_cur.vec_valid = 1'b0;
                    nxt_cur.state = (cpu_type_select == CPU_ONE_PULSE) ?
                                    ST_IDLE : ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (ack_rise)
                begin
                    nxt_cur.state = ST_SECOND;
                    nxt_cur.vec_valid = 1'b1;
                end
            end
            ST_SECOND:
            begin
                if (!ack_now)
                begin
                    nxt_cur.state = ST_IDLE;
                    nxt_cur.vec_valid = 1'b0;
                end
            end
            default:
            begin
                nxt_cur.state = ST_IDLE;
                nxt_cur.vec_valid = 1'b0;
            end
        endcase
        ack_busy = (nxt_cur.state != ST_IDLE);
        nxt_cur.phantom_oe_n = ~ack_busy;
        nxt_cur.mem_dis = ack_busy ||
            (phantom_disable_option && !cur_ff.phan_s2) ||
            (phantom_enable_option && cur_ff.phan_s2);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_ff <= '0;
            cur_ff.src_s1 <= 8'h00;
            cur_ff.vi_s1 <= 8'hff;
            cur_ff.vi_s2 <= 8'hff;
            cur_ff.ack_s1 <= 1'b1;
            cur_ff.ack_s2 <= 1'b1;
            cur_ff.phan_s1 <= 1'b1;
            cur_ff.phan_s2 <= 1'b1;
            cur_ff.state <= ST_IDLE;
            cur_ff.vi_oe_n <= OE_N_RESET;
            cur_ff.int_oe_n <= 1'b1;
            cur_ff.phantom_oe_n <= 1'b1;
            cur_ff.vector <= VEC_RESET;
            cur_ff.tgate <= 3'h7;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign vi_n_out = 8'h00;
    assign vi_n_oe_n = cur_ff.vi_oe_n;
    assign int_n_out = 1'b0;
    assign int_n_oe_n = cur_ff.int_oe_n;
    assign phantom_n_out = 1'b0;
    assign phantom_n_oe_n = cur_ff.phantom_oe_n;
    assign mem_disable = cur_ff.mem_dis;
    assign vector_out = cur_ff.vector;
    assign vector_valid = cur_ff.vec_valid;
    assign timer_gate = cur_ff.tgate;
    assign timer_out = cur_ff.tout;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ack_start;
        take;
    endsequence

    sequence s_cascade_take;
        take && m_int && (m_best == CASCADE_INPUT);
    endsequence

    property p_phantom_in_ack;
        (cur_ff.state != ST_IDLE) |-> !phantom_n_oe_n;
    endproperty
    a_phantom_in_ack: assert property (p_phantom_in_ack)
        else $error("phantom not driven during acknowledge");

    property p_mem_forced;
        s_ack_start |=> mem_disable;
    endproperty
    a_mem_forced: assert property (p_mem_forced)
        else $error("memory not disabled during acknowledge");

    property p_one_pulse;
        s_ack_start ##0 (cpu_type_select == CPU_ONE_PULSE) |=> vector_valid;
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("one-pulse acknowledge gave no vector");

    property p_two_pulse;
        s_ack_start ##0 (cpu_type_select == CPU_TWO_PULSE) |=>
            !vector_valid && (cur_ff.state == ST_FIRST);
    endproperty
    a_two_pulse: assert property (p_two_pulse)
        else $error("two-pulse acknowledge gave vector early");

    property p_int_follow;
        m_int |=> !int_n_oe_n;
    endproperty
    a_int_follow: assert property (p_int_follow)
        else $error("bus interrupt not driven");

    property p_cascade_vec;
        s_cascade_take |=>
            vector_out == SLAVE_VEC_BASE + {5'h00, $past(s_best)};
    endproperty
    a_cascade_vec: assert property (p_cascade_vec)
        else $error("cascade vector wrong");

    property p_master_prio;
        s_ack_start ##0 (m_best != CASCADE_INPUT) |=>
            vector_out == MASTER_VEC_BASE + {5'h00, $past(m_best)};
    endproperty
    a_master_prio: assert property (p_master_prio)
        else $error("master request lost priority");

    property p_route_line0;
        (bus_line_routing_header[3:0] == 4'h1) && srcv[SRC_RX] &&
            $stable(bus_line_routing_header[3:0]) |=> !vi_n_oe_n[0];
    endproperty
    a_route_line0: assert property (p_route_line0)
        else $error("routed source did not drive bus line");

    property p_gate_default;
        !cur_ff.gate_s2[3] |=> timer_gate[0];
    endproperty
    a_gate_default: assert property (p_gate_default)
        else $error("undriven timer gate not enabled");
endmodule : cascaded_interrupt_routing

// ==== hw/irq_core.sv ====
// Purpose: One fixed-priority interrupt controller, input 0 highest
// Assumes: Requests are level, high active, on the clk domain
// Notes: A take marks the best request in service; eoi clears the top one
`timescale 1ns/1ps
module irq_core
    import cascade_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] req,
    input wire logic take,
    input wire logic eoi,
    output logic int_req,
    output logic [2:0] best
);
    typedef struct packed {
        logic [7:0] isr;
    } core_s;

    core_s cur_ff;
    core_s nxt_cur;

    always_comb
    begin
        logic blk;
        logic [7:0] allowed;
        logic [7:0] pend;
        logic [7:0] clr;
        logic hit;
        blk = 1'b0;
        allowed = 8'h00;
        pend = 8'h00;
        clr = 8'h00;
        hit = 1'b0;
        best = 3'h0;
        nxt_cur = cur_ff;
        for (int i = 0; i < 8; i++)
        begin
            allowed[i] = ~blk;
            blk = blk | cur_ff.isr[i];
        end
        pend = req & ~cur_ff.isr & allowed;
        int_req = |pend;
        for (int i = 7; i >= 0; i--)
        begin
            if (pend[i])
            begin
                best = 3'(i);
            end
        end
        for (int i = 0; i < 8; i++)
        begin
            if (cur_ff.isr[i] && !hit)
            begin
                clr[i] = 1'b1;
                hit = 1'b1;
            end
        end
        if (eoi)
        begin
            nxt_cur.isr = nxt_cur.isr & ~clr;
        end
        if (take && int_req)
        begin
            nxt_cur.isr[best] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end
endmodule : irq_core
